/* File: pwmr_defines.svh */
// Purpose: Register offsets, field positions and reset values of the three-channel PWM.
// Assumes: Byte addresses on a 32-bit AHB-Lite bus, one aligned word per register.
// Notes: Definitions only; included by the top module.
`ifndef PWMR_DEFINES_SVH
`define PWMR_DEFINES_SVH

// Register offset inside one channel window (address bits 4:0).
`define PWMR_OFF_TC 5'h00
`define PWMR_OFF_DC 5'h04
`define PWMR_OFF_RUN 5'h08
`define PWMR_OFF_DIV 5'h0C
`define PWMR_OFF_SYNC 5'h10
`define PWMR_OFF_POL 5'h14
// Channel window select (address bits 6:5); window 3 is the broadcast set.
`define PWMR_WIN_BCAST 2'h3
// Status register byte address (address bit 7 set).
`define PWMR_ADDR_STATUS 8'h80
// Divide value field bits used; bit 0 below them is ignored.
`define PWMR_DIVVAL_MSB 5
`define PWMR_DIVVAL_LSB 1
// Reset values.
`define PWMR_RST_CNT 16'h0000
`define PWMR_RST_DIV 6'h00
`define PWMR_RST_BIT 1'b0

`endif

/* File: pwmr_pkg.sv */
// Purpose: Types shared by the three-channel PWM.
// Assumes: Numbers live in pwmr_defines.svh.
// Notes: None.
package pwmr_pkg;

  // Channel lifecycle state.
  typedef enum logic [1:0] {
    ST_STOP = 2'b00,
    ST_ARMED = 2'b01,
    ST_RUN = 2'b10
  } pwmr_st_t;

  // One channel's waveform settings, held both as buffer and as active copy.
  typedef struct packed {
    logic [5:0] divide_value;
    logic [15:0] tc;
    logic [15:0] dc;
    logic polarity_bit;
  } pwmr_cfg_t;

endpackage : pwmr_pkg

/* File: pwmr_top.sv */
// Purpose: Three-channel PWM with double-buffered settings behind an AHB-Lite slave.
// Assumes: Counter 0 pulse may come from another clock, so it is synchronised.
// Notes: Reads take one wait state, writes none.
// Notes: A status word at its own address shows the running, armed and output bits.
// Notes: A divide value of zero or one is illegal; such a channel then ticks every 64 clocks.
// Notes: Start mode writes are not blocked while running; software must stop the channel first.
// Behaviour
// [RULE_01] Even divide 2 to 62, bit 0 ignored.
// [RULE_02] Divided tick enables each channel's waveform logic.
// [RULE_03] Software accesses holding buffers, not active values.
// [RULE_04] Enable write while stopped loads all buffers.
// [RULE_05] Running channel loads buffers at cycle end.
// [RULE_06] Counts 8 bits for 0,1; 16 for 2.
// [RULE_07] Broadcast counts load all three, truncated.
// [RULE_08] Broadcast divider loads all three divider buffers.
// [RULE_09] Broadcast polarity and start mode load all.
// [RULE_10] Broadcast enable sets all, updates stopped channels.
// [RULE_11] Polarity picks off-first or on-first order.
// [RULE_12] Clearing enable stops at cycle end.
// [RULE_13] Stopped output equals polarity bit.
// [RULE_14] Enable in normal mode starts immediately.
// [RULE_15] Enable in synchronous mode only arms.
// [RULE_16] Start mode 0 normal, 1 synchronous.
// [RULE_17] Software changes start mode only while stopped.
// [RULE_18] Outputs offered as counter gate sources.
// [RULE_19] Period divide times terminal count plus one.
// [RULE_20] Armed channels start in order per pulse.
// [RULE_21] Outputs low in and after reset, halted.
// [RULE_22] Count tc+1 ticks, duty interval dc ticks.
`timescale 1ns/1ps
`include "pwmr_defines.svh"

module pwmr_top #(
  parameter int NARROW_W = 8, // Count width of channels 0 and 1.
  parameter int WIDE_W = 16 // Count width of channel 2.
) (
  input wire logic i_ref_clk, // 40 MHz clock.
  input wire logic i_rstn, // Asynchronous active-low reset.
  input wire logic i_hsel, // Slave select.
  input wire logic [31:0] i_haddr, // Byte address.
  input wire logic [1:0] i_htrans, // Transfer type.
  input wire logic i_hwrite, // Write when high.
  input wire logic [2:0] i_hsize, // Transfer size, words only.
  input wire logic [31:0] i_hwdata, // Write data.
  input wire logic i_hready, // Bus ready.
  output logic o_hreadyout, // Slave ready.
  output logic o_hresp, // Always OKAY.
  output logic [31:0] o_hrdata, // Read data.
  input wire logic i_ctr0_pulse, // Counter 0 output pulse.
  output logic [2:0] o_channel_output, // Waveform outputs.
  output logic [2:0] o_gate_src // Copies offered to the counter gates.
);
  import pwmr_pkg::*;

  // Masks that cut a written count to each channel's width.
  localparam logic [15:0] NARROW_MASK = 16'((32'h1 << NARROW_W) - 32'h1);
  localparam logic [15:0] WIDE_MASK = 16'((32'h1 << WIDE_W) - 32'h1);

  // Width mask of a channel.
  function automatic logic [15:0] width_mask(input int ch);
    return (ch == 2) ? WIDE_MASK : NARROW_MASK; // RULE_06
  endfunction : width_mask

  // Effective divide ratio with the low bit forced to zero.
  // An odd written value therefore divides like the even value just below it.
  // A field of zero or one gives a ratio of zero, which the prescaler wraps as 64.
  function automatic logic [5:0] eff_div(input logic [5:0] divide_value);
    return {divide_value[`PWMR_DIVVAL_MSB:`PWMR_DIVVAL_LSB], 1'b0}; // RULE_01
  endfunction : eff_div

  // Output level while running: the last dc states are the duty interval.
  // With polarity clear the cycle shows the off interval first, then dc ticks high.
  // With polarity set the same shape is inverted, so dc then sets the low interval.
  // The threshold is one bit wider than the count, so a terminal count of all ones still works.
  function automatic logic wave_level(input pwmr_cfg_t c, input logic [15:0] n);
    logic [16:0] thr;
    thr = {1'b0, c.tc} + 17'h00001 - {1'b0, c.dc};
    return ({1'b0, n} >= thr) ^ c.polarity_bit; // RULE_11 RULE_22
  endfunction : wave_level

  // Bus state: pending data phases and the captured address.
  logic wr_pend; // A write is in its data phase.
  logic rd_pend; // A read is in its wait cycle.
  logic rd_done; // A read is in its final data cycle.
  logic [7:0] a_addr; // Captured low address bits.
  logic [31:0] rdata; // Registered read data.
  logic next_wr_pend;
  logic next_rd_pend;
  logic next_rd_done;
  logic [7:0] next_a_addr;
  logic [31:0] next_rdata;
  logic take; // Address phase accepted this cycle.

  // Channel state.
  pwmr_cfg_t buf_cfg [3]; // Holding buffers seen by software.
  pwmr_cfg_t act_cfg [3]; // Active settings used by the waveform.
  pwmr_st_t st [3]; // Lifecycle state.
  logic [5:0] div_cnt [3]; // Prescaler count.
  logic [15:0] cnt [3]; // Tick count within a cycle.
  logic [2:0] run_bit; // Enable bits.
  logic [2:0] sync_bit; // Start mode bits.
  logic [2:0] out; // Registered outputs.
  pwmr_cfg_t next_buf [3];
  pwmr_cfg_t next_act [3];
  pwmr_st_t next_st [3];
  logic [5:0] next_div_cnt [3];
  logic [15:0] next_cnt [3];
  logic [2:0] next_run_bit;
  logic [2:0] next_sync_bit;
  logic [2:0] next_out;
  logic [2:0] en_wr; // Enable register written this cycle.
  logic [2:0] tick; // Divided clock tick.
  logic [2:0] eoc; // End of output cycle.
  logic [2:0] grant; // Start granted by the counter pulse.

  // Counter pulse synchroniser and edge detector.
  logic [1:0] ctr_sync; // Two-stage synchroniser.
  logic ctr_prev; // Previous synchronised level.
  logic pulse_edge; // One-cycle start pulse.

  // Accept an address phase, hold reads one wait cycle, register read data.
  // The wait cycle lets the read data come from a flip-flop rather than from the decoder.
  // Writes need no wait: the data phase word is applied at the end of its own cycle.
  always_comb begin
    take = i_hsel & i_htrans[1] & i_hready;
    next_wr_pend = take & i_hwrite;
    next_rd_pend = take & ~i_hwrite;
    next_rd_done = rd_pend;
    next_a_addr = take ? i_haddr[7:0] : a_addr;
    next_rdata = rdata;
    if (rd_pend) begin
      // Read the buffers and the status, never the active copies.
      next_rdata = 32'h00000000;
      if (a_addr == `PWMR_ADDR_STATUS) begin
        for (int i = 0; i < 3; i++) begin
          next_rdata[i] = (st[i] == ST_RUN);
          next_rdata[4 + i] = (st[i] == ST_ARMED);
          next_rdata[8 + i] = out[i];
        end
      end else if (!a_addr[7] && a_addr[6:5] != `PWMR_WIN_BCAST) begin
        case (a_addr[4:0]) // RULE_03
          `PWMR_OFF_TC: next_rdata[15:0] = buf_cfg[a_addr[6:5]].tc;
          `PWMR_OFF_DC: next_rdata[15:0] = buf_cfg[a_addr[6:5]].dc;
          `PWMR_OFF_RUN: next_rdata[0] = run_bit[a_addr[6:5]];
          `PWMR_OFF_DIV: next_rdata[5:0] = buf_cfg[a_addr[6:5]].divide_value;
          `PWMR_OFF_SYNC: next_rdata[0] = sync_bit[a_addr[6:5]];
          `PWMR_OFF_POL: next_rdata[0] = buf_cfg[a_addr[6:5]].polarity_bit;
          default: next_rdata = 32'h00000000;
        endcase
      end
    end
  end

  // Register the bus state.
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      rd_done <= 1'b0;
      a_addr <= 8'h00;
      rdata <= 32'h00000000;
    end else begin
      wr_pend <= next_wr_pend;
      rd_pend <= next_rd_pend;
      rd_done <= next_rd_done;
      a_addr <= next_a_addr;
      rdata <= next_rdata;
    end
  end

  assign o_hreadyout = ~rd_pend;
  assign o_hresp = 1'b0;
  assign o_hrdata = rdata;

  // Synchronise the counter pulse; only the second stage feeds the edge detector.
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ctr_sync <= 2'b00;
      ctr_prev <= 1'b0;
    end else begin
      ctr_sync <= {ctr_sync[0], i_ctr0_pulse};
      ctr_prev <= ctr_sync[1];
    end
  end

  assign pulse_edge = ctr_sync[1] & ~ctr_prev;

  // Buffer writes, start and stop sequencing, dividers, counters and outputs.
  // The first loop decodes software writes into the holding buffers and picks
  // the channel that a counter pulse starts. The second loop runs each channel's
  // lifecycle: stopped, armed for a counter pulse, or running. The active copy
  // changes only on an enable write while not running, or at a cycle end.
  always_comb begin
    logic hit;
    logic found;
    hit = 1'b0;
    found = 1'b0;
    next_run_bit = run_bit;
    next_sync_bit = sync_bit;
    en_wr = 3'b000;
    grant = 3'b000;
    for (int i = 0; i < 3; i++) begin
      next_buf[i] = buf_cfg[i];
      // A channel window hit or a broadcast hit writes this channel.
      hit = wr_pend && !a_addr[7] && (a_addr[6:5] == 2'(i) || a_addr[6:5] == `PWMR_WIN_BCAST);
      if (hit) begin
        case (a_addr[4:0])
          `PWMR_OFF_TC: next_buf[i].tc = i_hwdata[15:0] & width_mask(i); // RULE_07 RULE_03
          `PWMR_OFF_DC: next_buf[i].dc = i_hwdata[15:0] & width_mask(i); // RULE_07
          `PWMR_OFF_DIV: next_buf[i].divide_value = i_hwdata[5:0]; // RULE_08
          `PWMR_OFF_POL: next_buf[i].polarity_bit = i_hwdata[0]; // RULE_09
          // Start mode goes straight to its register; it is not double buffered.
          `PWMR_OFF_SYNC: next_sync_bit[i] = i_hwdata[0]; // RULE_09 RULE_16 RULE_17
          // An enable write also flags the buffer transfer for a channel that is not running.
          `PWMR_OFF_RUN: begin
            next_run_bit[i] = i_hwdata[0]; // RULE_10
            en_wr[i] = 1'b1;
          end
          default: hit = 1'b0;
        endcase
      end
      // The lowest-numbered armed channel takes each counter pulse.
      if (pulse_edge && !found && st[i] == ST_ARMED) begin
        grant[i] = 1'b1; // RULE_20
        found = 1'b1;
      end
    end
    for (int i = 0; i < 3; i++) begin
      next_act[i] = act_cfg[i];
      next_st[i] = st[i];
      next_div_cnt[i] = div_cnt[i];
      next_cnt[i] = cnt[i];
      // The prescaler tick is the divided clock; it enables the tick counter below.
      // Only a running channel advances its prescaler, so every cycle starts aligned.
      tick[i] = (div_cnt[i] == eff_div(act_cfg[i].divide_value) - 6'h01); // RULE_02 RULE_01
      eoc[i] = (st[i] == ST_RUN) && tick[i] && (cnt[i] == act_cfg[i].tc); // RULE_19
      unique case (st[i])
        // Stopped: counters held at zero, output parked at the polarity level.
        ST_STOP: begin
          next_div_cnt[i] = `PWMR_RST_DIV;
          next_cnt[i] = `PWMR_RST_CNT;
          if (en_wr[i]) begin
            next_act[i] = buf_cfg[i]; // RULE_04 RULE_10
            if (next_run_bit[i]) begin
              next_st[i] = sync_bit[i] ? ST_ARMED : ST_RUN; // RULE_14 RULE_15 RULE_16
            end
          end
        end
        ST_ARMED: begin
          // Still not running, so an enable write reloads the buffers.
          if (en_wr[i]) begin
            next_act[i] = buf_cfg[i]; // RULE_04
            if (!next_run_bit[i]) begin
              next_st[i] = ST_STOP;
            end
          end else if (grant[i]) begin
            next_st[i] = ST_RUN; // RULE_15
          end
        end
        // Running: the cycle end reloads the buffers and honours a cleared enable.
        ST_RUN: begin
          next_div_cnt[i] = tick[i] ? `PWMR_RST_DIV : div_cnt[i] + 6'h01; // RULE_02
          if (tick[i]) begin
            next_cnt[i] = eoc[i] ? `PWMR_RST_CNT : cnt[i] + 16'h0001; // RULE_22 RULE_19
          end
          if (eoc[i]) begin
            next_act[i] = buf_cfg[i]; // RULE_05
            if (!next_run_bit[i]) begin
              next_st[i] = ST_STOP; // RULE_12
            end
          end
        end
        default: next_st[i] = ST_STOP;
      endcase
      // Running shows the waveform, otherwise the polarity level.
      // The output is computed from next values so it changes on the same edge as the state.
      next_out[i] = (next_st[i] == ST_RUN) ? wave_level(next_act[i], next_cnt[i]) : next_act[i].polarity_bit; // RULE_13
    end
  end

  // Register the channel state; reset leaves all channels halted, normal, low.
  // Buffers reset to zero, which is an illegal divide value until software writes one.
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      for (int i = 0; i < 3; i++) begin
        buf_cfg[i] <= '0;
        act_cfg[i] <= '0;
        st[i] <= ST_STOP; // RULE_21
        div_cnt[i] <= `PWMR_RST_DIV;
        cnt[i] <= `PWMR_RST_CNT;
      end
      run_bit <= 3'h0;
      sync_bit <= 3'h0; // RULE_21
      out <= 3'h0; // RULE_21
    end else begin
      for (int i = 0; i < 3; i++) begin
        buf_cfg[i] <= next_buf[i];
        act_cfg[i] <= next_act[i];
        st[i] <= next_st[i];
        div_cnt[i] <= next_div_cnt[i];
        cnt[i] <= next_cnt[i];
      end
      run_bit <= next_run_bit;
      sync_bit <= next_sync_bit;
      out <= next_out;
    end
  end

  assign o_channel_output = out;
  assign o_gate_src = out; // RULE_18

  // Checks on the channel behaviour.
  // All checks run on the one clock and are quiet while reset is low.
  // Each channel gets its own copy of the per-channel checks.
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rstn);

  for (genvar g = 0; g < 3; g++) begin : g_chk
    a_stop_level: assert property ((st[g] == ST_STOP) |-> (out[g] == act_cfg[g].polarity_bit)) // RULE_13
      else $error("Stopped channel output differs from polarity.");
    a_normal_start: assert property ((st[g] == ST_STOP && en_wr[g] && next_run_bit[g] && !sync_bit[g])
      |=> (st[g] == ST_RUN)) // RULE_14
      else $error("Normal mode enable did not start the channel.");
    a_sync_arm: assert property ((st[g] == ST_STOP && en_wr[g] && next_run_bit[g] && sync_bit[g])
      |=> (st[g] == ST_ARMED)) // RULE_15
      else $error("Synchronous enable did not arm the channel.");
    a_load_stopped: assert property ((st[g] == ST_STOP && en_wr[g]) |=> (act_cfg[g] == $past(buf_cfg[g]))) // RULE_04
      else $error("Stopped enable write did not load buffers.");
    a_hold_running: assert property ((st[g] == ST_RUN && !eoc[g]) |=> $stable(act_cfg[g])) // RULE_05
      else $error("Active settings changed inside a cycle.");
    a_stop_at_end: assert property ((st[g] == ST_RUN && !eoc[g]) |=> (st[g] != ST_STOP)) // RULE_12
      else $error("Channel stopped before its cycle end.");
    a_div_two: assert property ((st[g] == ST_RUN && tick[g] && !eoc[g] && eff_div(act_cfg[g].divide_value) == 6'h02)
      |=> !tick[g] ##1 tick[g]) // RULE_01
      else $error("Divide by two tick spacing wrong.");
    // A cycle end must restart the tick count from zero.
    a_cycle_wrap: assert property ((st[g] == ST_RUN && eoc[g]) |=> (cnt[g] == `PWMR_RST_CNT)) // RULE_22
      else $error("Tick count did not restart after cycle end.");
    // Buffered terminal counts never hold bits beyond the channel's width.
    a_count_width: assert property ((buf_cfg[g].tc & ~width_mask(g)) == 16'h0000) // RULE_06
      else $error("Terminal count buffer wider than its channel.");
    // An armed channel waits until a pulse or an enable write moves it.
    a_arm_wait: assert property ((st[g] == ST_ARMED && !en_wr[g] && !grant[g]) |=> (st[g] == ST_ARMED)) // RULE_15
      else $error("Armed channel left armed without a pulse.");
  end

  a_sync_order: assert property (grant[1] |-> (st[0] != ST_ARMED)) // RULE_20
    else $error("Channel 1 started ahead of armed channel 0.");
  a_bcast_count: assert property ((wr_pend && a_addr == {1'b0, `PWMR_WIN_BCAST, `PWMR_OFF_TC})
    |=> (buf_cfg[0].tc == {8'h00, $past(i_hwdata[7:0])} && buf_cfg[2].tc == $past(i_hwdata[15:0]))) // RULE_07
    else $error("Broadcast terminal count not spread.");

  c_run0: cover property (st[0] == ST_RUN ##1 eoc[0]);
  c_grant2: cover property (grant[2]);
  c_stop_end: cover property (eoc[1] && !run_bit[1]);
  c_bcast_en: cover property (en_wr == 3'h7);

endmodule : pwmr_top

/* File: pwmr_ctr0_model.sv */
// Purpose: Counter 0 pulse source standing in for the on-chip counter/timer.
// Assumes: The bench spaces its requests so the pulse is low between them.
// Notes: Each request gives one pulse, high for PULSE_LEN clocks.
`timescale 1ns/1ps
module pwmr_ctr0_model #(
  parameter int PULSE_LEN = 2 // High time of one pulse in clocks.
) (
  input wire logic i_ref_clk, // System clock.
  input wire logic i_rstn, // Active-low reset.
  input wire logic i_fire, // One-cycle request for a pulse.
  output logic o_pulse // Counter 0 output pulse.
);
  int cnt; // Clocks of high time left.
  int next_cnt; // Next value of the high time left.
  // Load the high time on a request, otherwise count it down to zero.
  always_comb begin
    next_cnt = (cnt > 0) ? cnt - 1 : 0;
    if (i_fire) begin
      next_cnt = PULSE_LEN;
    end
  end
  // Register the count, so the pulse changes just after a clock edge.
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt <= 0;
    end else begin
      cnt <= next_cnt;
    end
  end
  assign o_pulse = (cnt > 0);
endmodule : pwmr_ctr0_model

/* File: pwmr_top_bench.sv */
// Purpose: Self-checking bench of the three-channel PWM over AHB-Lite.
// Assumes: Read wait states follow hreadyout; no fixed bus latency is used.
// Notes: Holding buffers are mirrored in an integer model.
`timescale 1ns/1ps
module pwmr_top_bench;
  logic clk, rstn, hsel, hwrite, fire, hreadyout, hresp, pulse; // Bus and pulse lines.
  logic [31:0] haddr, hwdata, hrdata, rd, seed; // Bus data and random state.
  logic [1:0] htrans; // Transfer type.
  logic [2:0] hsize, outp, gate; // Size and channel outputs.
  int bad_count, n_checks, d, tc, dc, pol, hi, per; // Counters and settings.
  int mbuf[3][6]; // Model of every channel's holding buffers.
  pwmr_top #(.NARROW_W(8), .WIDE_W(16)) uut (.i_ref_clk(clk), .i_rstn(rstn), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
    .i_hready(hreadyout), .o_hreadyout(hreadyout), .o_hresp(hresp), .o_hrdata(hrdata),
    .i_ctr0_pulse(pulse), .o_channel_output(outp), .o_gate_src(gate));
  pwmr_ctr0_model #(.PULSE_LEN(2)) ctr0 (.i_ref_clk(clk), .i_rstn(rstn), .i_fire(fire), .o_pulse(pulse));
  // Free-running 40 MHz clock.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Xorshift source of the random settings.
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  // Compare one value and count the outcome.
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // Print the counts and the verdict, then stop.
  task complete_run();
    $display("Checks %0d, mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run
  // One single AHB-Lite transfer; read data lands in rd.
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int k;
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    k = 0;
    do begin @(posedge clk); k++; end while (hreadyout !== 1'b1 && k < 50);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do begin @(posedge clk); k++; end while (hreadyout !== 1'b1 && k < 50);
    rd = hrdata;
    if (k >= 50) begin
      bad_count++;
    end
  endtask : bus
  // Write a register and mirror it into the model, broadcast window included.
  task wr(input logic [7:0] a, input logic [31:0] v);
    int o;
    bus(1'b1, a, v);
    o = a[4:0] / 4;
    if (!a[7] && a[1:0] == 2'h0 && o < 6) begin
      for (int c = 0; c < 3; c++) begin
        if (a[6:5] == c || a[6:5] == 2'h3) begin
          mbuf[c][o] = (o < 2) ? v & (c < 2 ? 32'h000000FF : 32'h0000FFFF) : (o == 3 ? v & 32'h3F : v & 32'h1);
        end
      end
    end
  endtask : wr
  // Read a register and compare it with an expected value.
  task rchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h00000000);
    chk("hrdata", rd, e);
  endtask : rchk
  // Read one holding buffer and compare it with the model.
  task rbuf(input int c, input int o);
    rchk(8'(c * 32 + o * 4), mbuf[c][o]);
  endtask : rbuf
  // Read the running and armed bits of the status word.
  task st(input logic [31:0] e);
    bus(1'b0, 8'h80, 32'h00000000);
    chk("status", rd & 32'h00000077, e);
  endtask : st
  // Measure one output cycle from rising edge to rising edge.
  task meas(input int c);
    logic p;
    int k;
    hi = 0;
    per = 0;
    k = 0;
    do begin p = outp[c]; @(posedge clk); k++; end while (!(p === 1'b0 && outp[c] === 1'b1) && k < 3000);
    do begin
      hi += (outp[c] === 1'b1);
      per++;
      p = outp[c];
      @(posedge clk);
    end while (!(p === 1'b0 && outp[c] === 1'b1) && per < 3000);
    chk("gate_src", 32'(gate), 32'(outp));
  endtask : meas
  // Ask the counter model for one pulse and let the start settle.
  task fire_once();
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    repeat (10) @(posedge clk);
  endtask : fire_once
  // Watchdog that ends a hung run as a failure.
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    complete_run();
  end
  // Main sequence.
  initial begin
    {rstn, hsel, hwrite, fire, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    seed = 32'd15811;
    bad_count = 0;
    n_checks = 0;
    repeat (8) @(posedge clk);
    chk("out_reset", 32'(outp), 32'h0);
    rstn <= 1'b1;
    @(posedge clk);
    chk("hresp", 32'(hresp), 32'h0);
    for (int o = 0; o < 6; o++) rbuf(2, o);
    st(32'h00);
    wr(8'h18, 32'h0000FFFF);
    rchk(8'h18, 32'h0);
    rchk(8'h84, 32'h0);
    for (int c = 0; c < 3; c++) begin
      d = 2 + 2 * (rnd() % 3);
      tc = 2 + rnd() % 4;
      dc = 1 + rnd() % tc;
      pol = rnd() % 2;
      wr(8'(c * 32 + 12), 32'(d | 1));
      wr(8'(c * 32), 32'(tc));
      wr(8'(c * 32 + 4), 32'(dc));
      wr(8'(c * 32 + 20), 32'(pol));
      rbuf(c, 0);
      rbuf(c, 1);
      rbuf(c, 5);
      wr(8'(c * 32 + 8), 32'h1);
      meas(c);
      chk("period", per, d * (tc + 1));
      chk("high_time", hi, pol ? d * (tc + 1 - dc) : d * dc);
      wr(8'(c * 32), 32'(tc + 2));
      meas(c);
      chk("no_glitch", 32'(per == d * (tc + 1) || per == d * (tc + 3)), 32'h1);
      meas(c);
      chk("new_period", per, d * (tc + 3));
      wr(8'(c * 32 + 8), 32'h0);
    end
    repeat (200) @(posedge clk);
    wr(8'h60, 32'h00001203);
    rbuf(0, 0);
    rbuf(2, 0);
    wr(8'h60, 32'h3);
    wr(8'h64, 32'h1);
    wr(8'h6C, 32'h2);
    wr(8'h74, 32'h1);
    for (int c = 0; c < 3; c++) begin
      rbuf(c, 3);
      rbuf(c, 5);
    end
    wr(8'h68, 32'h1);
    st(32'h07);
    meas(2);
    chk("bcast_period", per, 8);
    chk("bcast_high", hi, 6);
    wr(8'h68, 32'h0);
    hi = 0;
    for (int k = 0; k < 30; k++) begin
      d = outp[2];
      @(posedge clk);
      hi += (d == 1 && outp[2] === 1'b0);
    end
    chk("falls_after_stop", hi, 1);
    chk("stopped_level", 32'(outp), 32'h7);
    st(32'h00);
    wr(8'h70, 32'h1);
    rbuf(1, 4);
    wr(8'h30, 32'h0);
    wr(8'h74, 32'h0);
    wr(8'h68, 32'h1);
    st(32'h52);
    fire_once();
    st(32'h43);
    fire_once();
    st(32'h07);
    fire_once();
    st(32'h07);
    complete_run();
  end
endmodule : pwmr_top_bench
